/* File: ifas_status.sv */
// FIFO level, status, SDA hold and transmit abort cause logic with AHB-Lite registers
//
// Summary of operation
// - TX empty flag set when level zero
// - TX not-full flag set while space remains
// - Activity bit is master OR slave activity
// - TX level readable in five-bit field
// - TX level cleared on disable or abort
// - TX level counts pushes minus pops
// - RX level readable in five-bit field
// - RX level cleared on disable or abort
// - RX level counts received minus read entries
// - Programmable SDA hold after SCL fall
// - Sixteen-bit abort cause register
// - Clear reads clear all but newly caused bits, bit nine always
// - Software removes bit nine cause first
// - Bit nine reasserts after one cleared cycle
// - Bit nine on start byte without restart
// - Bit fifteen on read command to slave read
// - Bits fourteen and twelve on slave mismatch
// - Bit thirteen flushes stale TX data
// - Bit twelve on master arbitration loss
// - Bit eleven when master mode disabled
// - Bit ten on ten-bit read without restart
//
// Notes for users of this block
// The levels are counters of pushes and pops; the FIFO storage itself sits outside.
// A push at full or a pop at empty is dropped, so a level can never wrap around.
// Any abort cause clears both levels in the same cycle, matching the flush that follows.
// A disabled controller holds both levels at zero and keeps the flush strobe high.
// Abort bits other than 9 take a new cause over a clear read, so no event is lost.
// Bit 9 obeys a clear read for one cycle even while its cause stays, then sets again.
// Software must withdraw the bit 9 cause before a clear read removes it for good.
// The abort pulse output follows any cause by one cycle; it is not an interrupt.
// The hold timer only starts on an SCL fall while the slave state machine reports activity.
// A hold value of zero releases SDA on the cycle after the sampled SCL fall.
// A new SCL fall restarts the hold count, so a fall before the count ends delays the release.
// Offsets outside this map read as zero and ignore writes; read-only words ignore writes.
// The transfer size is not checked: every register is one aligned 32-bit word.
// The slave never stalls the bus and always answers OKAY, so reads need no wait state.
// Read data is captured at the end of the address phase and stands until the next read.
// Register writes land at the end of the data phase, one cycle after the address.
// Control bit 0 enables the controller and control bit 5 enables restart generation.
// Status bits: activity, TX not full, TX empty, RX not empty, RX full, master, slave.
// Bus-side events are single-cycle pulses; the two activity inputs are levels.
// Abort cause inputs are levels that are sampled on every clock edge.
// The depths and level width are parameters; the level must be wide enough for a depth.
module ifas_status
    import ifas_pkg::*;
#(
    parameter int TX_DEPTH = 16,
    parameter int RX_DEPTH = 16,
    parameter int LVL_W = 5,
    parameter logic [15:0] HOLD_DEFAULT = IFAS_HOLD_RST
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Bus-side events
    input wire ifas_fifo_ev_t fifo_ev,
    input wire ifas_abort_ev_t abort_ev,
    input wire logic scl_fall,
    // Derived outputs
    output logic tx_abort_pulse,
    output logic tx_flush,
    output logic sda_release
);

    // Register state
    logic [LVL_W-1:0] tx_level_r, tx_level_nxt;
    logic [LVL_W-1:0] rx_level_r, rx_level_nxt;
    logic [15:0] hold_r;
    logic [15:0] abrt_r, abrt_nxt;
    logic [7:0] ctrl_r;
    logic [15:0] hold_cnt_r;
    logic hold_busy_r;
    logic tx_abort_r;
    logic tx_flush_r;
    logic sda_release_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;

    // Address phase capture
    logic dp_valid_r;
    logic dp_write_r;
    logic [7:0] dp_addr_r;

    // Address phase decode
    wire logic ap_take = hsel && hready && (htrans == IFAS_HTRANS_NONSEQ);
    wire logic [7:0] ap_addr = haddr[7:0];
    wire logic ap_read = ap_take && !hwrite;
    wire logic clr_read = ap_read &&
        ((ap_addr == IFAS_OFF_CLR_INTR) || (ap_addr == IFAS_OFF_CLR_ABRT));
    wire logic wr_hold = dp_valid_r && dp_write_r && (dp_addr_r == IFAS_OFF_HOLD);
    wire logic wr_ctrl = dp_valid_r && dp_write_r && (dp_addr_r == IFAS_OFF_CTRL);
    wire logic enabled = ctrl_r[IFAS_CT_EN];
    wire logic restart_en = ctrl_r[IFAS_CT_RESTART];

    // Level update shared by both FIFOs
    // A clear wins over counting, since the FIFO contents are flushed in that cycle.
    // The callers already drop a push at full and a pop at empty, so the count
    // never wraps; a push and a pop in one cycle leave the level unchanged.
    function automatic logic [LVL_W-1:0] level_step(
        input logic [LVL_W-1:0] level,
        input logic clear,
        input logic inc,
        input logic dec
    );
        logic [LVL_W-1:0] result;
        result = level;
        if (clear) begin
            result = '0;
        end else if (inc && !dec) begin
            result = level + LVL_W'(1);
        end else if (dec && !inc) begin
            result = level - LVL_W'(1);
        end
        return result;
    endfunction

    // FIFO status flags derived from counters, so flags and levels always agree; activity comes from the two state machine inputs
    // empty flag
    wire logic tx_empty = (tx_level_r == '0);
    wire logic tx_full = (tx_level_r == LVL_W'(TX_DEPTH));
    wire logic tx_not_full = !tx_full;
    wire logic rx_empty = (rx_level_r == '0);
    wire logic rx_full = (rx_level_r == LVL_W'(RX_DEPTH));
    wire logic activity = fifo_ev.mst_active | fifo_ev.slv_active;

    // Status word assembled bit by bit from the package positions
    logic [6:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[IFAS_ST_ACT] = activity;
        status_word[IFAS_ST_TFNF] = tx_not_full;
        status_word[IFAS_ST_TFE] = tx_empty;
        status_word[IFAS_ST_RFNE] = !rx_empty;
        status_word[IFAS_ST_RFF] = rx_full;
        status_word[IFAS_ST_MST] = fifo_ev.mst_active;
        status_word[IFAS_ST_SLV] = fifo_ev.slv_active;
    end

    // Abort cause sources; bit 9 cause remains while restart disabled and start requested
    // start byte without restart
    wire logic sbyte_cause = !restart_en && abort_ev.sbyte_attempt &&
        (abort_ev.special_cmd || abort_ev.general_call_or_start_select);
    wire logic flush_cause = abort_ev.slv_read_req && !tx_empty;
    logic [15:0] abrt_set;
    always_comb begin
        abrt_set = '0;
        abrt_set[IFAS_AB_SBYTE] = sbyte_cause;
        abrt_set[IFAS_AB_10B_RD] = !restart_en && abort_ev.ten_bit_read;
        abrt_set[IFAS_AB_MST_DIS] = abort_ev.mst_start_req && !abort_ev.master_mode;
        // arbitration loss, slave loss sets bit 12 too
        abrt_set[IFAS_AB_ARB] = abort_ev.mst_arb_lost || abort_ev.slv_sda_mismatch;
        abrt_set[IFAS_AB_FLUSH] = flush_cause;
        abrt_set[IFAS_AB_SLV_ARB] = abort_ev.slv_sda_mismatch;
        abrt_set[IFAS_AB_SLVRD] = abort_ev.slvrd_cmd_write;
    end
    wire logic any_abort = |abrt_set;

    // Abort register next value
    // For every bit but 9 a new cause wins over a clear read, so no event is lost.
    // Bit 9 is the exception: a clear read drops it for exactly one cycle even while
    // its cause stays, and the standing cause sets it again on the following edge.
    // Software that polls right after a clear may therefore still see bit 9 set.
    // sixteen cause bits
    logic [15:0] abrt_kept;
    always_comb begin
        abrt_kept = (clr_read ? IFAS_ABRT_RST : abrt_r) | abrt_set;
        if (clr_read) begin
            abrt_kept[IFAS_AB_SBYTE] = 1'b0;
        end
    end
    // once the cause is removed the cleared bit stays clear
    assign abrt_nxt = abrt_kept;

    // Transmit level: clear wins over counting since the FIFO is flushed
    // clear conditions
    wire logic tx_clear = !enabled || any_abort || fifo_ev.slv_bulk_abort;
    wire logic tx_inc = fifo_ev.tx_push && !tx_full;
    wire logic tx_dec = fifo_ev.tx_pop && !tx_empty;
    assign tx_level_nxt = level_step(tx_level_r, tx_clear, tx_inc, tx_dec);

    // Receive level
    // clear conditions
    wire logic rx_clear = !enabled || any_abort;
    wire logic rx_inc = fifo_ev.rx_push && !rx_full;
    wire logic rx_dec = fifo_ev.rx_pop && (rx_level_r != '0);
    assign rx_level_nxt = level_step(rx_level_r, rx_clear, rx_inc, rx_dec);

    // Read mux, decoded in the address phase so data is ready in the data phase
    logic [31:0] rd_mux;
    always_comb begin
        case (ap_addr)
            IFAS_OFF_STATUS: rd_mux = {25'h0000000, status_word};
            IFAS_OFF_TXFLR: rd_mux = {{(32 - LVL_W){1'b0}}, tx_level_r};
            IFAS_OFF_RXFLR: rd_mux = {{(32 - LVL_W){1'b0}}, rx_level_r};
            IFAS_OFF_HOLD: rd_mux = {16'h0000, hold_r};
            IFAS_OFF_ABRT: rd_mux = {16'h0000, abrt_r};
            IFAS_OFF_CTRL: rd_mux = {24'h000000, ctrl_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Bus phase tracking and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else begin
            dp_valid_r <= ap_take;
            dp_write_r <= hwrite;
            dp_addr_r <= ap_addr;
            if (ap_read) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // Software-written registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_r <= HOLD_DEFAULT;
            ctrl_r <= 8'h00;
        end else begin
            if (wr_hold) begin
                hold_r <= hwdata[15:0];
            end
            if (wr_ctrl) begin
                ctrl_r <= hwdata[7:0];
            end
        end
    end

    // Counters and abort register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_level_r <= '0;
            rx_level_r <= '0;
            abrt_r <= IFAS_ABRT_RST;
            tx_abort_r <= 1'b0;
            tx_flush_r <= 1'b0;
        end else begin
            tx_level_r <= tx_level_nxt;
            rx_level_r <= rx_level_nxt;
            abrt_r <= abrt_nxt;
            tx_abort_r <= any_abort;
            tx_flush_r <= tx_clear;
        end
    end

    // SDA hold timer: SDA may change only after the hold count elapses
    // A zero hold lets SDA change on the cycle after the fall; a new fall restarts counting.
    // The count is in core clock periods, so the hold in time scales with the clock.
    // Outside slave activity a fall is ignored, since only a slave transmitter holds SDA.
    // hold after SCL fall
    wire logic hold_start = scl_fall && fifo_ev.slv_active;
    wire logic hold_last = hold_busy_r && (hold_cnt_r == 16'h0001);
    logic [15:0] hold_cnt_nxt;
    logic hold_busy_nxt;
    logic sda_release_nxt;
    always_comb begin
        hold_cnt_nxt = hold_cnt_r;
        hold_busy_nxt = hold_busy_r;
        sda_release_nxt = 1'b0;
        if (hold_start) begin
            hold_cnt_nxt = hold_r;
            hold_busy_nxt = (hold_r != 16'h0000);
            sda_release_nxt = (hold_r == 16'h0000);
        end else if (hold_busy_r) begin
            hold_cnt_nxt = hold_cnt_r - 16'h0001;
            hold_busy_nxt = !hold_last;
            sda_release_nxt = hold_last;
        end
    end

    // Hold timer registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_cnt_r <= 16'h0000;
            hold_busy_r <= 1'b0;
            sda_release_r <= 1'b0;
        end else begin
            hold_cnt_r <= hold_cnt_nxt;
            hold_busy_r <= hold_busy_nxt;
            sda_release_r <= sda_release_nxt;
        end
    end

    // Handshake flops: the slave never inserts wait states and always answers OKAY;
    // kept in registers so that every output of the block leaves a flip-flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    // Outputs straight from flip-flops
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign tx_abort_pulse = tx_abort_r;
    assign tx_flush = tx_flush_r;
    assign sda_release = sda_release_r;

endmodule

/* File: ifas_pkg.sv */
// Package: register map, field layout, reset values and types of the FIFO/abort status block
package ifas_pkg;

    // Register byte addresses
    localparam logic [7:0] IFAS_OFF_STATUS = 8'h70;
    localparam logic [7:0] IFAS_OFF_TXFLR = 8'h74;
    localparam logic [7:0] IFAS_OFF_RXFLR = 8'h78;
    localparam logic [7:0] IFAS_OFF_HOLD = 8'h7C;
    localparam logic [7:0] IFAS_OFF_ABRT = 8'h80;
    localparam logic [7:0] IFAS_OFF_CLR_INTR = 8'h40;
    localparam logic [7:0] IFAS_OFF_CLR_ABRT = 8'h54;
    localparam logic [7:0] IFAS_OFF_CTRL = 8'h84;

    // Status bit positions
    localparam int IFAS_ST_ACT = 0;
    localparam int IFAS_ST_TFNF = 1;
    localparam int IFAS_ST_TFE = 2;
    localparam int IFAS_ST_RFNE = 3;
    localparam int IFAS_ST_RFF = 4;
    localparam int IFAS_ST_MST = 5;
    localparam int IFAS_ST_SLV = 6;

    // Abort cause bit positions
    localparam int IFAS_AB_10B_RD = 10;
    localparam int IFAS_AB_MST_DIS = 11;
    localparam int IFAS_AB_ARB = 12;
    localparam int IFAS_AB_FLUSH = 13;
    localparam int IFAS_AB_SLV_ARB = 14;
    localparam int IFAS_AB_SLVRD = 15;
    localparam int IFAS_AB_SBYTE = 9;

    // Control register bit positions (enable, restart enable)
    localparam int IFAS_CT_EN = 0;
    localparam int IFAS_CT_RESTART = 5;

    // Reset values
    localparam logic [15:0] IFAS_HOLD_RST = 16'h0001;
    localparam logic [15:0] IFAS_ABRT_RST = 16'h0000;
    localparam int IFAS_ABRT_W = 16;

    // AHB transfer type
    localparam logic [1:0] IFAS_HTRANS_NONSEQ = 2'h2;

    // Bus-side events that drive the status logic
    typedef struct packed {
        logic tx_push;          // Software pushed a transmit entry
        logic tx_pop;           // Bus side removed a transmit entry
        logic rx_push;          // Received byte entered receive FIFO
        logic rx_pop;           // Software removed a receive entry
        logic slv_bulk_abort;   // Slave bulk transmit aborted
        logic mst_active;       // Master state machine not idle
        logic slv_active;       // Slave state machine not idle
    } ifas_fifo_ev_t;

    typedef struct packed {
        logic sbyte_attempt;    // Start byte requested
        logic special_cmd;      // Special-command bit of target register
        logic general_call_or_start_select;      // General-call-or-start select
        logic slvrd_cmd_write;  // Slave read answered with read command word
        logic slv_sda_mismatch; // SDA differs at SCL rise in slave transmit
        logic slv_read_req;     // Slave read command received
        logic mst_arb_lost;     // Master lost arbitration
        logic mst_start_req;    // Master transfer requested
        logic master_mode;      // Master mode enabled
        logic ten_bit_read;     // Master read with 10-bit address
    } ifas_abort_ev_t;

endpackage

/* File: ifas_status_assertions.sv */
// Checker: output timing of the FIFO status and abort cause block
module ifas_status_assertions
    import ifas_pkg::*;
(
    // Clock, reset and AHB
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Events and outputs
    input wire ifas_fifo_ev_t fifo_ev,
    input wire ifas_abort_ev_t abort_ev,
    input wire logic scl_fall,
    input wire logic tx_abort_pulse,
    input wire logic tx_flush,
    input wire logic sda_release
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr_hold_r;
    logic [15:0] hold_r;
    // Shadow of the hold field so the release delay can be predicted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_hold_r <= 1'b0;
            hold_r <= IFAS_HOLD_RST;
        end else begin
            wr_hold_r <= hsel && hready && htrans == IFAS_HTRANS_NONSEQ && hwrite
                && haddr[7:0] == IFAS_OFF_HOLD;
            if (wr_hold_r)
                hold_r <= hwdata[15:0];
        end
    end
    sequence release_after_one;
        !sda_release ##1 sda_release;
    endsequence
    sequence release_after_three;
        !sda_release [*3] ##1 sda_release;
    endsequence
    slvrd_abort_a: assert property ($rose(abort_ev.slvrd_cmd_write) |=> tx_abort_pulse)
        else $error("no abort pulse after read command word");
    slv_arb_abort_a: assert property ($rose(abort_ev.slv_sda_mismatch) |=> tx_abort_pulse)
        else $error("no abort pulse after slave data mismatch");
    arb_lost_abort_a: assert property ($rose(abort_ev.mst_arb_lost) |=> tx_abort_pulse)
        else $error("no abort pulse after lost arbitration");
    master_dis_abort_a: assert property ($rose(abort_ev.mst_start_req) && !abort_ev.master_mode
        |=> tx_abort_pulse) else $error("no abort pulse for disabled master");
    abort_flush_a: assert property (tx_abort_pulse |-> tx_flush)
        else $error("abort without transmit flush");
    bulk_flush_a: assert property (fifo_ev.slv_bulk_abort |=> tx_flush)
        else $error("bulk abort without transmit flush");
    hold_one_a: assert property (scl_fall && fifo_ev.slv_active && hold_r == 16'h0001
        |=> release_after_one) else $error("release not two cycles after fall");
    hold_three_a: assert property (scl_fall && fifo_ev.slv_active && hold_r == 16'h0003
        |=> release_after_three) else $error("release not four cycles after fall");
    okay_resp_a: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with error");
endmodule
bind ifas_status ifas_status_assertions i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .fifo_ev(fifo_ev), .abort_ev(abort_ev),
    .scl_fall(scl_fall), .tx_abort_pulse(tx_abort_pulse), .tx_flush(tx_flush),
    .sda_release(sda_release));

/* File: ifas_bus_model.sv */
// Model of the two-wire bus side: FIFO events, abort causes and SCL falls
module ifas_bus_model
    import ifas_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Events towards the block
    output ifas_fifo_ev_t fifo_ev,
    output ifas_abort_ev_t abort_ev,
    output logic scl_fall
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle: no events, master mode on, no cause
    initial begin
        fifo_ev = '0;
        abort_ev = 10'h002;
        scl_fall = 1'b0;
    end
    // One-cycle pulses with a gap, so each counts exactly once
    task automatic pulse(input ifas_fifo_ev_t m, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            fifo_ev <= fifo_ev | m;
            @(posedge hclk);
            fifo_ev <= fifo_ev & ~m;
        end
    endtask
    task automatic levels(input logic mst, input logic slv);
        @(posedge hclk);
        fifo_ev.mst_active <= mst;
        fifo_ev.slv_active <= slv;
    endtask
    // Causes are levels; the bench withdraws a cause by setting idle again
    // cause removal
    task automatic set_cause(input ifas_abort_ev_t v);
        @(posedge hclk);
        abort_ev <= v;
    endtask
    task automatic sda_fall;
        @(posedge hclk);
        scl_fall <= 1'b1;
        @(posedge hclk);
        scl_fall <= 1'b0;
    endtask
endmodule

/* File: testbench.sv */
// Testbench: register-level checks of the FIFO status and abort cause block
module testbench
    import ifas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_abort_pulse, tx_flush, sda_release;
    logic scl_fall;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd_v;
    ifas_fifo_ev_t fifo_ev;
    ifas_abort_ev_t abort_ev;
    int err_count = 0;
    int checks_done = 0;
    int n;
    ifas_abort_ev_t cause_in [6] = '{10'h042, 10'h022, 10'h00A, 10'h004, 10'h003, 10'h012};
    logic [15:0] cause_exp [6] = '{16'h8000, 16'h5000, 16'h1000, 16'h0800, 16'h0400, 16'h2000};
    logic [15:0] hold_set [2] = '{16'h0003, 16'h0001};
    wire hready = hreadyout;
    ifas_status i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fifo_ev(fifo_ev),
        .abort_ev(abort_ev), .scl_fall(scl_fall), .tx_abort_pulse(tx_abort_pulse),
        .tx_flush(tx_flush), .sda_release(sda_release));
    ifas_bus_model i_bus (.hclk(hclk), .fifo_ev(fifo_ev), .abort_ev(abort_ev),
        .scl_fall(scl_fall));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    task automatic complete_run;
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %08h expected %08h", $time, seen, exp);
        end
    endtask
    // Bounded wait: a stuck hready ends the run rather than hanging it
    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 100);
        if (hready !== 1'b1) begin
            err_count++;
            complete_run;
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= IFAS_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        rd_v = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(rd_v, exp);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, an unmapped word, then enable with restart off
        rd(IFAS_OFF_STATUS, 32'h6);
        rd(IFAS_OFF_HOLD, 32'h1);
        rd(IFAS_OFF_ABRT, 32'h0);
        rd(8'h90, 32'h0);
        ahb(1'b1, IFAS_OFF_CTRL, 32'h1);
        ahb(1'b1, IFAS_OFF_TXFLR, 32'h5);
        rd(IFAS_OFF_TXFLR, 32'h0);
        // One push beyond full must be ignored
        i_bus.pulse(7'h40, 17);
        rd(IFAS_OFF_TXFLR, 32'h10);
        rd(IFAS_OFF_STATUS, 32'h0);
        i_bus.pulse(7'h20, 1);
        rd(IFAS_OFF_STATUS, 32'h2);
        rd(IFAS_OFF_TXFLR, 32'hF);
        i_bus.pulse(7'h20, 15);
        rd(IFAS_OFF_STATUS, 32'h6);
        i_bus.pulse(7'h10, 3);
        i_bus.pulse(7'h08, 1);
        rd(IFAS_OFF_RXFLR, 32'h2);
        i_bus.levels(1'b1, 1'b0);
        rd(IFAS_OFF_STATUS, 32'h2F);
        i_bus.levels(1'b0, 1'b1);
        rd(IFAS_OFF_STATUS, 32'h4F);
        // Disable empties both levels and bulk abort empties the TX level
        i_bus.pulse(7'h40, 2);
        ahb(1'b1, IFAS_OFF_CTRL, 32'h0);
        rd(IFAS_OFF_TXFLR, 32'h0);
        rd(IFAS_OFF_RXFLR, 32'h0);
        check(32'(tx_flush), 32'h1);
        ahb(1'b1, IFAS_OFF_CTRL, 32'h1);
        i_bus.pulse(7'h40, 2);
        i_bus.pulse(7'h04, 1);
        rd(IFAS_OFF_TXFLR, 32'h0);
        // Every cause but start byte, with stale entries queued, cleared by both clear reads
        for (int i = 0; i < 6; i++) begin
            i_bus.pulse(7'h50, 1);
            i_bus.set_cause(cause_in[i]);
            i_bus.set_cause(10'h002);
            rd(IFAS_OFF_ABRT, {16'h0, cause_exp[i]});
            rd(IFAS_OFF_TXFLR, 32'h0);
            rd(IFAS_OFF_RXFLR, 32'h0);
            ahb(1'b0, i[0] ? IFAS_OFF_CLR_INTR : IFAS_OFF_CLR_ABRT, 32'h0);
            rd(IFAS_OFF_ABRT, 32'h0);
        end
        // Start byte without restart: bit nine returns until the cause goes
        i_bus.set_cause(10'h302);
        rd(IFAS_OFF_ABRT, 32'h200);
        ahb(1'b0, IFAS_OFF_CLR_ABRT, 32'h0);
        rd(IFAS_OFF_ABRT, 32'h200);
        i_bus.set_cause(10'h002);
        ahb(1'b0, IFAS_OFF_CLR_INTR, 32'h0);
        rd(IFAS_OFF_ABRT, 32'h0);
        // Hold field keeps 16 bits; release counted from the sampled fall
        for (int i = 0; i < 2; i++) begin
            ahb(1'b1, IFAS_OFF_HOLD, {16'hABCD, hold_set[i]});
            rd(IFAS_OFF_HOLD, {16'h0, hold_set[i]});
            i_bus.sda_fall;
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (sda_release !== 1'b1 && n < 20);
            check(32'(n), {16'h0, hold_set[i]} + 32'h1);
        end
        complete_run;
    end
endmodule
